/* src/cmd_decode.sv */
// Decoder from command code to action requests; 0x0004 raises two of them
`timescale 1ns/1ps
module cmd_decode (
  // Command word
  input wire logic valid,
  input wire logic [15:0] code,
  // Decoded actions
  output logic fact_regs,
  output logic fact_cal,
  output logic energy_save,
  output logic energy_clear,
  output logic ext_all,
  output logic [meter_cfg_pkg::EXT_COUNT-1:0] ext_sel
);

  // Unlisted codes leave every output low
  always_comb begin
    fact_regs = valid && (code == meter_cfg_pkg::CMD_FACT_ALL ||
                          code == meter_cfg_pkg::CMD_FACT_PARAM); // [R2]
    fact_cal = valid && (code == meter_cfg_pkg::CMD_FACT_ALL ||
                         code == meter_cfg_pkg::CMD_FACT_CAL); // [R4]
    energy_save = valid && code == meter_cfg_pkg::CMD_ENERGY_SAVE; // [R5]
    energy_clear = valid && code == meter_cfg_pkg::CMD_ENERGY_CLEAR; // [R6]
    ext_all = valid && code == meter_cfg_pkg::CMD_EXT_ALL; // [R7]
    for (int i = 0; i < meter_cfg_pkg::EXT_COUNT; i++) begin
      ext_sel[i] = valid && code == meter_cfg_pkg::CMD_EXT_FIRST + 16'(i); // [R7]
    end
  end

endmodule

/* src/meter_cfg_pkg.sv */
// Constants shared by the meter command and configuration register pair
package meter_cfg_pkg;

  // ----------------------------------------------------------------
  // Register addresses and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] CMD_ADDR = 16'h004d;
  localparam logic [15:0] PSET_ADDR = 16'h004e;
  localparam logic [15:0] PSET_RESET = 16'h0000;
  // Writable bits of the parameter set: 6..10 and 12..15
  localparam logic [15:0] PSET_WMASK = 16'hf7c0;

  // ----------------------------------------------------------------
  // Parameter set field positions
  // ----------------------------------------------------------------
  localparam int PEAK_LSB = 6;
  localparam int AUTO_LSB = 8;
  localparam int SCALE_LSB = 12;
  localparam int NEUTRAL_BIT = 15;
  localparam logic [1:0] PEAK_RSVD = 2'h3;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [15:0] CMD_FACT_ALL = 16'h0004;
  localparam logic [15:0] CMD_FACT_PARAM = 16'h0005;
  localparam logic [15:0] CMD_FACT_CAL = 16'h0006;
  localparam logic [15:0] CMD_ENERGY_SAVE = 16'h0011;
  localparam logic [15:0] CMD_ENERGY_CLEAR = 16'h0012;
  localparam logic [15:0] CMD_EXT_ALL = 16'h0021;
  localparam logic [15:0] CMD_EXT_FIRST = 16'h0022;
  localparam int EXT_COUNT = 8;

  // ----------------------------------------------------------------
  // Persistent store identifiers
  // ----------------------------------------------------------------
  localparam logic [5:0] PSET_ID = 6'h02;
  localparam logic [5:0] PARAM_ID_MAX = 6'h28;

endpackage

/* src/meter_command_and_config_regs.sv */
// Command and parameter-set register pair of a three-phase meter
//
// Summary of operation
// [R1] The parameter set is mirrored to persistent storage by numbered identifier on every bus write and factory restore.
// [R2] Code 0x0004 restores registers, parameters and calibration data to factory values.
// [R3] Code 0x0005 restores registers and parameters but leaves calibration data alone.
// [R4] Code 0x0006 restores only the calibration data.
// [R5] Code 0x0011 commits accumulated energy to persistent storage at once.
// [R6] Code 0x0012 zeroes every energy accumulator.
// [R7] Code 0x0021 clears all extremes and 0x0022 to 0x0029 clear one extreme each in order.
// [R8] Bits 7:6 choose the peak-measurement phase, with value 3 reserved.
// [R9] Bits 8 to 10 enable automatic min/max deletion for phases one to three.
// [R10] Bits 12 to 14 enable transformer-divisor current scaling for phases one to three.
// [R11] Bit 15 enables transformer-divisor scaling of the neutral current.
// [R12] The register master programs every transformer divisor between 1 and 2500.
// [R13] Reserved bits 0 to 5 and 11 ignore writes and read as zero.
// [R14] Each command write fires its action once and unlisted codes do nothing.
`timescale 1ns/1ps
module meter_command_and_config_regs (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // Register access port
  input wire logic [15:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_RD,
  output logic [15:0] REG_RDATA,
  output logic REG_RVALID,
  // Persistent store restore and write
  input wire logic NV_RESTORE,
  input wire logic [15:0] NV_RESTORE_DATA,
  output logic NV_WR_REQ,
  output logic [5:0] NV_WR_ID,
  output logic [15:0] NV_WR_DATA,
  // Action pulses
  output logic FACTORY_REGS,
  output logic FACTORY_CAL,
  output logic ENERGY_SAVE,
  output logic ENERGY_CLEAR,
  output logic EXTREME_CLEAR_ALL,
  output logic [meter_cfg_pkg::EXT_COUNT-1:0] EXTREME_CLEAR,
  // Configuration
  output logic [1:0] PEAK_PHASE,
  output logic [2:0] AUTO_CLEAR_EN,
  output logic [2:0] CT_SCALE_EN,
  output logic CT_SCALE_N
);

  localparam int EXTN = meter_cfg_pkg::EXT_COUNT;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Masks reserved bits and refuses the reserved phase code
  function automatic logic [15:0] merge_pset(input logic [15:0] old_v,
                                             input logic [15:0] new_v);
    logic [15:0] res;
    res = new_v & meter_cfg_pkg::PSET_WMASK; // [R13]
    if (res[meter_cfg_pkg::PEAK_LSB +: 2] == meter_cfg_pkg::PEAK_RSVD) begin
      res[meter_cfg_pkg::PEAK_LSB +: 2] = old_v[meter_cfg_pkg::PEAK_LSB +: 2]; // [R8]
    end
    return res;
  endfunction

  logic cmd_wr;
  logic pset_wr;
  logic d_fact_regs;
  logic d_fact_cal;
  logic d_save;
  logic d_clear;
  logic d_ext_all;
  logic [EXTN-1:0] d_ext;

  // Address decode; the command word is decoded in the same cycle
  assign cmd_wr = REG_WR && REG_ADDR == meter_cfg_pkg::CMD_ADDR;
  assign pset_wr = REG_WR && REG_ADDR == meter_cfg_pkg::PSET_ADDR;

  cmd_decode u_decode (
    .valid(cmd_wr),
    .code(REG_WDATA),
    .fact_regs(d_fact_regs),
    .fact_cal(d_fact_cal),
    .energy_save(d_save),
    .energy_clear(d_clear),
    .ext_all(d_ext_all),
    .ext_sel(d_ext)
  );

  // ----------------------------------------------------------------
  // Action pulses
  // ----------------------------------------------------------------
  logic [EXTN+4:0] act_reg;
  logic [EXTN+4:0] act_next;

  // Pulses last one cycle because the decode is only live on the write
  always_comb begin
    act_next = {d_ext, d_ext_all, d_clear, d_save, d_fact_cal, d_fact_regs}; // [R14]
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      act_reg <= '0;
    end else begin
      act_reg <= act_next;
    end
  end

  assign FACTORY_REGS = act_reg[0]; // [R3]
  assign FACTORY_CAL = act_reg[1];
  assign ENERGY_SAVE = act_reg[2];
  assign ENERGY_CLEAR = act_reg[3];
  assign EXTREME_CLEAR_ALL = act_reg[4];
  assign EXTREME_CLEAR = act_reg[EXTN+4:5];

  // ----------------------------------------------------------------
  // Parameter set and persistent mirror
  // ----------------------------------------------------------------
  logic [15:0] pset_reg;
  logic [15:0] pset_next;
  logic save_reg;
  logic save_next;
  logic [15:0] nvdata_reg;
  logic [15:0] nvdata_next;

  // Factory restore outranks a bus write, which outranks a restore from store.
  // A restore from store is not written back, so power-up stays quiet.
  always_comb begin
    pset_next = pset_reg;
    save_next = 1'b0;
    if (FACTORY_REGS) begin
      pset_next = meter_cfg_pkg::PSET_RESET; // [R3]
      save_next = 1'b1;
    end else if (pset_wr) begin
      pset_next = merge_pset(pset_reg, REG_WDATA);
      save_next = 1'b1; // [R1]
    end else if (NV_RESTORE) begin
      pset_next = merge_pset(pset_reg, NV_RESTORE_DATA); // [R1]
    end
    nvdata_next = save_next ? pset_next : nvdata_reg;
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pset_reg <= meter_cfg_pkg::PSET_RESET;
      save_reg <= 1'b0;
      nvdata_reg <= meter_cfg_pkg::PSET_RESET;
    end else begin
      pset_reg <= pset_next;
      save_reg <= save_next;
      nvdata_reg <= nvdata_next;
    end
  end

  assign NV_WR_REQ = save_reg;
  assign NV_WR_ID = meter_cfg_pkg::PSET_ID;
  assign NV_WR_DATA = nvdata_reg;

  // Configuration fields straight from the register
  assign PEAK_PHASE = pset_reg[meter_cfg_pkg::PEAK_LSB +: 2]; // [R8]
  assign AUTO_CLEAR_EN = pset_reg[meter_cfg_pkg::AUTO_LSB +: 3]; // [R9]
  assign CT_SCALE_EN = pset_reg[meter_cfg_pkg::SCALE_LSB +: 3]; // [R10]
  assign CT_SCALE_N = pset_reg[meter_cfg_pkg::NEUTRAL_BIT]; // [R11]

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;

  // Command register is write-only and unmapped addresses read zero
  always_comb begin
    rvalid_next = REG_RD;
    rdata_next = (REG_RD && REG_ADDR == meter_cfg_pkg::PSET_ADDR) ? pset_reg : 16'h0000;
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_reg <= 16'h0000;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign REG_RDATA = rdata_reg;
  assign REG_RVALID = rvalid_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  sequence s_cmd(logic [15:0] c);
    cmd_wr && REG_WDATA == c;
  endsequence

  sequence s_factory_saved;
    FACTORY_REGS ##1 (NV_WR_REQ && NV_WR_DATA == meter_cfg_pkg::PSET_RESET && PEAK_PHASE == 2'h0);
  endsequence

  property p_fact_all;
    s_cmd(meter_cfg_pkg::CMD_FACT_ALL) |=> FACTORY_REGS && FACTORY_CAL;
  endproperty
  a_fact_all: assert property (p_fact_all) else $error("full factory reset missed"); // [R2]

  property p_fact_param;
    s_cmd(meter_cfg_pkg::CMD_FACT_PARAM) |=> FACTORY_REGS && !FACTORY_CAL ##0 s_factory_saved;
  endproperty
  a_fact_param: assert property (p_fact_param) else $error("parameter reset wrong"); // [R3]

  property p_fact_cal;
    s_cmd(meter_cfg_pkg::CMD_FACT_CAL) |=> FACTORY_CAL && !FACTORY_REGS ##1 !NV_WR_REQ || $past(pset_wr);
  endproperty
  a_fact_cal: assert property (p_fact_cal) else $error("calibration reset wrong"); // [R4]

  property p_save;
    s_cmd(meter_cfg_pkg::CMD_ENERGY_SAVE) |=> ENERGY_SAVE && !ENERGY_CLEAR;
  endproperty
  a_save: assert property (p_save) else $error("energy save missed"); // [R5]

  property p_clear;
    s_cmd(meter_cfg_pkg::CMD_ENERGY_CLEAR) |=> ENERGY_CLEAR && !ENERGY_SAVE;
  endproperty
  a_clear: assert property (p_clear) else $error("energy clear missed"); // [R6]

  property p_ext;
    cmd_wr && REG_WDATA >= meter_cfg_pkg::CMD_EXT_FIRST && REG_WDATA <= 16'h0029 |=>
      EXTREME_CLEAR == EXTN'(1 << ($past(REG_WDATA) - meter_cfg_pkg::CMD_EXT_FIRST));
  endproperty
  a_ext: assert property (p_ext) else $error("wrong extreme cleared"); // [R7]

  property p_once;
    (|act_reg) |-> $past(cmd_wr) ##1 (!(|act_reg) || $past(cmd_wr));
  endproperty
  a_once: assert property (p_once) else $error("action fired without a write"); // [R14]

  property p_peak_rsvd;
    pset_wr && !FACTORY_REGS && REG_WDATA[meter_cfg_pkg::PEAK_LSB +: 2] == 2'h3
      |=> PEAK_PHASE == $past(PEAK_PHASE);
  endproperty
  a_peak_rsvd: assert property (p_peak_rsvd) else $error("reserved phase accepted"); // [R8]

  property p_auto;
    pset_wr && !FACTORY_REGS |=> AUTO_CLEAR_EN == $past(REG_WDATA[meter_cfg_pkg::AUTO_LSB +: 3]);
  endproperty
  a_auto: assert property (p_auto) else $error("auto clear enables wrong"); // [R9]

  property p_scale;
    pset_wr && !FACTORY_REGS |=> CT_SCALE_EN == $past(REG_WDATA[meter_cfg_pkg::SCALE_LSB +: 3]);
  endproperty
  a_scale: assert property (p_scale) else $error("phase scaling wrong"); // [R10]

  property p_neutral;
    pset_wr && !FACTORY_REGS |=> CT_SCALE_N == $past(REG_WDATA[meter_cfg_pkg::NEUTRAL_BIT]);
  endproperty
  a_neutral: assert property (p_neutral) else $error("neutral scaling wrong"); // [R11]

  property p_rsvd_read;
    REG_RVALID |-> (REG_RDATA & ~meter_cfg_pkg::PSET_WMASK) == 16'h0000;
  endproperty
  a_rsvd_read: assert property (p_rsvd_read) else $error("reserved bits read nonzero"); // [R13]

  // Store word must match the live configuration, not a read answer that may lag a write
  property p_persist;
    pset_wr && !FACTORY_REGS |=> NV_WR_REQ && NV_WR_ID == meter_cfg_pkg::PSET_ID &&
      NV_WR_DATA == {CT_SCALE_N, CT_SCALE_EN, 1'b0, AUTO_CLEAR_EN, PEAK_PHASE, 6'h00};
  endproperty
  a_persist: assert property (p_persist) else $error("parameter set not mirrored"); // [R1]

endmodule

/* test/meter_command_and_config_regs_test.sv */
// Self-checking bench for the meter command and parameter-set register pair
`timescale 1ns/1ps
module meter_command_and_config_regs_test;
  // ----------------------------------------------------------------
  // Stimulus, observed outputs and counters
  // ----------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic reg_wr = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_rd = 1'b0;
  logic nv_restore = 1'b0;
  logic [15:0] nv_restore_data = 16'h0000;
  logic [15:0] reg_rdata;
  logic reg_rvalid;
  logic nv_wr_req;
  logic [5:0] nv_wr_id;
  logic [15:0] nv_wr_data;
  logic fact_regs;
  logic fact_cal;
  logic en_save;
  logic en_clear;
  logic ext_all;
  logic [meter_cfg_pkg::EXT_COUNT-1:0] ext_one;
  logic [1:0] peak_phase;
  logic [2:0] auto_en;
  logic [2:0] ct_en;
  logic ct_n;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  // Action pulses as one word, and configuration levels laid out like the register
  wire [15:0] pulses = {3'h0, fact_regs, fact_cal, en_save, en_clear, ext_all, ext_one};
  wire [15:0] cfg_view = {ct_n, ct_en, 1'b0, auto_en, peak_phase, 6'h00};

  meter_command_and_config_regs dut_u (
    .REF_CLK(ref_clk), .RST_N(rst_n), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
    .REG_WDATA(reg_wdata), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid),
    .NV_RESTORE(nv_restore), .NV_RESTORE_DATA(nv_restore_data), .NV_WR_REQ(nv_wr_req),
    .NV_WR_ID(nv_wr_id), .NV_WR_DATA(nv_wr_data), .FACTORY_REGS(fact_regs),
    .FACTORY_CAL(fact_cal), .ENERGY_SAVE(en_save), .ENERGY_CLEAR(en_clear),
    .EXTREME_CLEAR_ALL(ext_all), .EXTREME_CLEAR(ext_one), .PEAK_PHASE(peak_phase),
    .AUTO_CLEAR_EN(auto_en), .CT_SCALE_EN(ct_en), .CT_SCALE_N(ct_n)
  );

  // ----------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end

  // The whole run needs about a hundred cycles; a stuck task ends here
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t ns: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Returns 1 ns after the taking edge, where the answer has landed
  task automatic reg_write(input logic [15:0] addr, input logic [15:0] data);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= addr;
    reg_wdata <= data;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic reg_read(input logic [15:0] addr, input logic [15:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= addr;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk({15'h0, reg_rvalid}, 16'h0001, "read answer");
    chk(reg_rdata, exp, "read data");
  endtask

  // Writes a parameter-set value and checks levels, store write and readback
  task automatic pset_write(input logic [15:0] data, input logic [15:0] exp);
    reg_write(meter_cfg_pkg::PSET_ADDR, data);
    chk(cfg_view, exp, "config levels");
    chk({15'h0, nv_wr_req}, 16'h0001, "store write");
    chk(nv_wr_data, exp, "store data");
    reg_read(meter_cfg_pkg::PSET_ADDR, exp);
  endtask

  // Issues one command code and expects the pulse pattern once only
  task automatic cmd(input logic [15:0] code, input logic [15:0] exp);
    reg_write(meter_cfg_pkg::CMD_ADDR, code);
    chk(pulses, exp, "action pulses");
    @(posedge ref_clk);
    #1;
    chk(pulses, 16'h0000, "pulse repeat");
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset_values();
    chk(cfg_view, 16'h0000, "reset config");
    chk(pulses, 16'h0000, "reset pulses");
    chk({10'h0, nv_wr_id}, {10'h0, meter_cfg_pkg::PSET_ID}, "store id");
    chk({15'h0, nv_wr_req}, 16'h0000, "reset store write");
    chk(nv_wr_data, 16'h0000, "reset store data");
    reg_read(meter_cfg_pkg::PSET_ADDR, 16'h0000);
  endtask

  // Reserved bits dropped, reserved peak code refused, other places harmless
  task automatic test_pset_fields();
    pset_write(16'h0080, 16'h0080);
    pset_write(16'hffff, 16'hf780);
    pset_write(16'h0740, 16'h0740);
    reg_write(16'h004f, 16'hffff);
    chk(cfg_view, 16'h0740, "unmapped write");
    // The master only ever programs a divisor in 1..2500; this block must not react to it
    reg_write(16'h0058, 16'h09c4);
    chk(cfg_view, 16'h0740, "divisor write");
    reg_read(16'h004f, 16'h0000);
    reg_read(meter_cfg_pkg::CMD_ADDR, 16'h0000);
  endtask

  // Every listed code, then codes that must do nothing
  task automatic test_commands();
    logic [15:0] codes [6] = '{16'h0004, 16'h0005, 16'h0006, 16'h0011, 16'h0012, 16'h0021};
    logic [15:0] exps [6] = '{16'h1800, 16'h1000, 16'h0800, 16'h0400, 16'h0200, 16'h0100};
    logic [15:0] bad [5] = '{16'h0000, 16'h0007, 16'h0013, 16'h002a, 16'h1004};
    for (int i = 0; i < 6; i++) begin
      cmd(codes[i], exps[i]);
    end
    for (int i = 0; i < 8; i++) begin
      cmd(16'h0022 + 16'(i), 16'h0001 << i);
    end
    for (int i = 0; i < 5; i++) begin
      cmd(bad[i], 16'h0000);
    end
  endtask

  // Calibration restore keeps the parameters; register restore clears them
  task automatic test_factory();
    pset_write(16'h5340, 16'h5340);
    cmd(16'h0006, 16'h0800);
    reg_read(meter_cfg_pkg::PSET_ADDR, 16'h5340);
    reg_write(meter_cfg_pkg::CMD_ADDR, 16'h0005);
    chk(pulses, 16'h1000, "register restore");
    @(posedge ref_clk);
    #1;
    chk(cfg_view, 16'h0000, "restored config");
    chk({15'h0, nv_wr_req}, 16'h0001, "restored store write");
    chk(nv_wr_data, 16'h0000, "restored store data");
    reg_read(meter_cfg_pkg::PSET_ADDR, 16'h0000);
  endtask

  // Load from the store applies the same field rules and writes nothing back
  task automatic test_restore();
    logic [15:0] vals [2] = '{16'h8c80, 16'h00c0};
    logic [15:0] exps [2] = '{16'h8480, 16'h0080};
    for (int i = 0; i < 2; i++) begin
      @(posedge ref_clk);
      nv_restore <= 1'b1;
      nv_restore_data <= vals[i];
      @(posedge ref_clk);
      nv_restore <= 1'b0;
      #1;
      chk(cfg_view, exps[i], "restored levels");
      chk({15'h0, nv_wr_req}, 16'h0000, "no write back");
    end
  endtask

  // ----------------------------------------------------------------
  // Closing report and main sequence
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    if (num_errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Reset in mid-run must drop a non-zero parameter set back to its factory value
  task automatic test_mid_reset();
    @(posedge ref_clk);
    rst_n <= 1'b0;
    #1;
    chk(cfg_view, 16'h0000, "config in reset");
    chk({15'h0, nv_wr_req}, 16'h0000, "store write in reset");
    @(posedge ref_clk);
    rst_n <= 1'b1;
    #1;
    reg_read(meter_cfg_pkg::PSET_ADDR, 16'h0000);
  endtask

  // Reset is released before the first bus request, since a read in reset gets no answer
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1;
    test_reset_values();
    test_pset_fields();
    test_commands();
    test_factory();
    test_restore();
    test_mid_reset();
    tally_and_finish();
  end
endmodule
